// ### aod_decoder.sv
// Consuming assembly decoder with Avalon-MM configuration registers
// How it works
// - Instances 20-23 fixed, 100 configurable
// - Class revision 0002h, max instance read-only
// - Instance data is read-only, one word per user item
// - Reject writes from non-permitted IP addresses
// - Instance 14h: fwd, fault reset, speed
// - Instance 15h adds reverse and network selects
// - Instance 16h: basic layout plus torque
// - Instance 17h: extended layout plus torque
// - User item size one to four bytes
// - Selector 9999 gives zero-length item
// - All 9999: no configurable connection
// - Duplicate selectors: lowest wins, others 9999
// - Nonexistent item target: bytes discarded
// - Fixed-format prefix first, items after
// - Items packed in order, low byte first
// - Prefix length zero, four or six bytes
// - Subindex from lower/upper parameter half
//
// The Avalon-MM slave port and the register addresses were decided locally.
`timescale 1ns/1ps
module aod_decoder (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  // Avalon-MM register slave
  input  wire logic [7:0]              avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic      [31:0]             avs_readdata,
  output logic                         avs_waitrequest,
  // Received frame from the scanner
  input  wire logic                    frm_start,
  input  wire aod_pkg::aod_frame_hdr_t frm_hdr,
  input  wire logic                    frm_valid,
  input  wire logic [7:0]              frm_data,
  input  wire logic                    frm_last,
  output logic                         frm_done,
  output logic                         frm_ok,
  // Item table of the drive
  input  wire logic [9:0]              item_exists,
  input  wire logic [9:0][1:0]         item_size_m1,
  // Drive side
  output aod_pkg::aod_drive_cmd_t      cmd,
  output logic                         cmd_update,
  output aod_pkg::aod_item_wr_t        item_wr,
  output logic                         item_wr_valid,
  output logic                         conn_enabled
);
  typedef enum {ST_IDLE, ST_RECV} aod_state_t;

  function automatic logic [5:0] fixed_len(input logic [15:0] f);
    if (f == 16'(aod_pkg::INST_BASIC) || f == 16'(aod_pkg::INST_EXT)) begin
      fixed_len = aod_pkg::LEN_SPEED;
    end else if (f == 16'(aod_pkg::INST_SPD_TRQ) ||
                 f == 16'(aod_pkg::INST_EXT_TRQ)) begin
      fixed_len = aod_pkg::LEN_SPEED_TRQ;
    end else begin
      fixed_len = 6'h00;
    end
  endfunction

  function automatic logic is_ext(input logic [7:0] f);
    is_ext = (f == aod_pkg::INST_EXT) || (f == aod_pkg::INST_EXT_TRQ);
  endfunction

  function automatic logic has_trq(input logic [7:0] f);
    has_trq = (f == aod_pkg::INST_SPD_TRQ) || (f == aod_pkg::INST_EXT_TRQ);
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
    for (int i = 0; i < 4; i++) begin
      be_merge[8*i +: 8] = be[i] ? wd[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  // Configuration registers
  logic [15:0] fmt_sel;
  logic [15:0] sel [aod_pkg::NUM_ITEMS];
  logic [15:0] subidx [aod_pkg::NUM_SUBIDX];
  logic        ip_check;
  logic [31:0] ip_lo;
  logic [31:0] ip_hi;
  logic [15:0] ok_count;
  logic [2:0]  last_rej;
  logic        ack;
  logic        rd_mem;
  logic [31:0] rd_reg;
  logic [15:0] next_fmt_sel;
  logic [15:0] next_sel [aod_pkg::NUM_ITEMS];
  logic [15:0] next_subidx [aod_pkg::NUM_SUBIDX];
  logic        next_ip_check;
  logic [31:0] next_ip_lo;
  logic [31:0] next_ip_hi;
  logic        next_ack;
  logic        next_rd_mem;
  logic [31:0] next_rd_reg;
  logic [31:0] mem_rdata;
  logic [3:0]  mem_raddr;
  logic [7:0]  sel_off;
  logic [7:0]  sub_off;
  logic [7:0]  val_off;

  // Frame state
  aod_state_t  state;
  aod_state_t  next_state;
  logic [5:0]  pos;
  logic [5:0]  next_pos;
  logic        accept;
  logic        next_accept;
  logic [2:0]  rej;
  logic [2:0]  next_rej;
  logic [7:0]  fmt;
  logic [7:0]  next_fmt;
  logic [5:0]  exp_len;
  logic [5:0]  next_exp_len;
  logic [5:0]  pref_len;
  logic [5:0]  next_pref_len;
  logic        overrun;
  logic        next_overrun;
  logic [7:0]  st_ctrl;
  logic [7:0]  next_st_ctrl;
  logic [15:0] st_spd;
  logic [15:0] next_st_spd;
  logic [15:0] st_trq;
  logic [15:0] next_st_trq;
  logic [31:0] acc;
  logic [31:0] next_acc;
  aod_pkg::aod_drive_cmd_t next_cmd;
  aod_pkg::aod_item_wr_t   next_item_wr;
  logic        next_item_wr_valid;
  logic        next_cmd_update;
  logic        next_frm_done;
  logic        next_frm_ok;
  logic [15:0] next_ok_count;
  logic [2:0]  next_last_rej;

  // Item layout
  logic [2:0]  len [aod_pkg::NUM_ITEMS];
  logic [5:0]  off [aod_pkg::NUM_ITEMS];
  logic [5:0]  total_len;
  logic [9:0]  hit;
  logic        all_none;

  // Effective item lengths with duplicate removal
  always_comb begin
    logic dup;
    logic [5:0] run;
    dup      = 1'b0;
    run      = fixed_len(fmt_sel);
    all_none = (fmt_sel == aod_pkg::SEL_NONE);
    for (int k = 0; k < aod_pkg::NUM_ITEMS; k++) begin
      dup = 1'b0;
      for (int j = 0; j < k; j++) begin
        if (sel[j] == sel[k]) begin
          dup = 1'b1;
        end
      end
      if (sel[k] == aod_pkg::SEL_NONE || dup) begin
        len[k] = 3'h0;
      end else begin
        len[k] = {1'b0, item_size_m1[k]} + 3'h1;
      end
      all_none = all_none && (sel[k] == aod_pkg::SEL_NONE);
      off[k]   = run;
      run      = run + {3'h0, len[k]};
    end
    total_len = run;
  end

  assign conn_enabled = ~all_none;

  // Which item holds the current byte
  for (genvar g = 0; g < aod_pkg::NUM_ITEMS; g++) begin : g_hit
    assign hit[g] = (len[g] != 3'h0) && (pos >= off[g]) &&
                    (pos < off[g] + {3'h0, len[g]});
  end

  // Register slave: one wait cycle, answer on the second edge
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign avs_readdata    = rd_mem ? mem_rdata : rd_reg;
  assign sel_off         = avs_address - aod_pkg::ADDR_SEL_BASE;
  assign sub_off         = avs_address - aod_pkg::ADDR_SUB_BASE;
  assign val_off         = avs_address - aod_pkg::ADDR_VAL_BASE;
  assign mem_raddr       = val_off[5:2];

  always_comb begin
    next_ack      = (avs_read | avs_write) & ~ack;
    next_rd_mem   = 1'b0;
    next_rd_reg   = 32'h0000_0000;
    next_fmt_sel  = fmt_sel;
    next_sel      = sel;
    next_subidx   = subidx;
    next_ip_check = ip_check;
    next_ip_lo    = ip_lo;
    next_ip_hi    = ip_hi;
    if (avs_read & ~ack) begin
      case (avs_address)
        aod_pkg::ADDR_CLASS_REV: next_rd_reg = {16'h0000,
                                                aod_pkg::CLASS_REVISION};
        aod_pkg::ADDR_MAX_INST:  next_rd_reg = {16'h0000,
                                                aod_pkg::MAX_INSTANCE};
        aod_pkg::ADDR_FORMAT:    next_rd_reg = {16'h0000, fmt_sel};
        aod_pkg::ADDR_IP_CTRL:   next_rd_reg = {31'h0, ip_check};
        aod_pkg::ADDR_IP_LO:     next_rd_reg = ip_lo;
        aod_pkg::ADDR_IP_HI:     next_rd_reg = ip_hi;
        aod_pkg::ADDR_STATUS:    next_rd_reg = {ok_count, 12'h000,
                                                last_rej, conn_enabled};
        default: begin
          if (sel_off < 8'h28 && sel_off[1:0] == 2'h0) begin
            next_rd_reg = {16'h0000, sel[sel_off[5:2]]};
          end else if (sub_off < 8'h14 && sub_off[1:0] == 2'h0) begin
            next_rd_reg = {16'h0000, subidx[sub_off[4:2]]};
          end else if (val_off < 8'h28 && val_off[1:0] == 2'h0) begin
            next_rd_mem = 1'b1;
          end
        end
      endcase
    end
    if (avs_write & ack) begin
      case (avs_address)
        aod_pkg::ADDR_FORMAT:  next_fmt_sel = 16'(be_merge({16'h0000, fmt_sel},
                                              avs_writedata, avs_byteenable));
        aod_pkg::ADDR_IP_CTRL: begin
          if (avs_byteenable[0]) begin
            next_ip_check = avs_writedata[0];
          end
        end
        aod_pkg::ADDR_IP_LO:   next_ip_lo = be_merge(ip_lo, avs_writedata,
                                                     avs_byteenable);
        aod_pkg::ADDR_IP_HI:   next_ip_hi = be_merge(ip_hi, avs_writedata,
                                                     avs_byteenable);
        default: begin
          if (sel_off < 8'h28 && sel_off[1:0] == 2'h0) begin
            next_sel[sel_off[5:2]] = 16'(be_merge({16'h0000,
              sel[sel_off[5:2]]}, avs_writedata, avs_byteenable));
          end else if (sub_off < 8'h14 && sub_off[1:0] == 2'h0) begin
            next_subidx[sub_off[4:2]] = 16'(be_merge({16'h0000,
              subidx[sub_off[4:2]]}, avs_writedata, avs_byteenable));
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack      <= 1'b0;
      rd_mem   <= 1'b0;
      rd_reg   <= 32'h0000_0000;
      fmt_sel  <= aod_pkg::RST_FORMAT;
      ip_check <= 1'b0;
      ip_lo    <= aod_pkg::RST_IP;
      ip_hi    <= aod_pkg::RST_IP;
      for (int k = 0; k < aod_pkg::NUM_ITEMS; k++) begin
        sel[k] <= aod_pkg::RST_SELECTOR;
      end
      for (int k = 0; k < aod_pkg::NUM_SUBIDX; k++) begin
        subidx[k] <= aod_pkg::RST_SUBIDX;
      end
    end else begin
      ack      <= next_ack;
      rd_mem   <= next_rd_mem;
      rd_reg   <= next_rd_reg;
      fmt_sel  <= next_fmt_sel;
      ip_check <= next_ip_check;
      ip_lo    <= next_ip_lo;
      ip_hi    <= next_ip_hi;
      sel      <= next_sel;
      subidx   <= next_subidx;
    end
  end

  // Frame reception and decoding
  always_comb begin
    logic [3:0] k;
    logic [5:0] b;
    k                  = 4'h0;
    b                  = 6'h00;
    next_state         = state;
    next_pos           = pos;
    next_accept        = accept;
    next_rej           = rej;
    next_fmt           = fmt;
    next_exp_len       = exp_len;
    next_pref_len      = pref_len;
    next_overrun       = overrun;
    next_st_ctrl       = st_ctrl;
    next_st_spd        = st_spd;
    next_st_trq        = st_trq;
    next_acc           = acc;
    next_cmd           = cmd;
    next_item_wr       = item_wr;
    next_item_wr_valid = 1'b0;
    next_cmd_update    = 1'b0;
    next_frm_done      = 1'b0;
    next_frm_ok        = frm_ok;
    next_ok_count      = ok_count;
    next_last_rej      = last_rej;
    if (frm_start) begin
      next_state    = ST_RECV;
      next_pos      = 6'h00;
      next_overrun  = 1'b0;
      next_rej      = aod_pkg::REJ_NONE;
      next_fmt      = frm_hdr.inst_no;
      next_exp_len  = fixed_len({8'h00, frm_hdr.inst_no});
      next_pref_len = next_exp_len;
      if (frm_hdr.inst_no == aod_pkg::INST_CONFIG) begin
        next_fmt      = fmt_sel[7:0];
        next_pref_len = fixed_len(fmt_sel);
        next_exp_len  = total_len;
        if (all_none) begin
          next_rej = aod_pkg::REJ_NO_CONN;
        end
      end else if (next_exp_len == 6'h00) begin
        next_rej = aod_pkg::REJ_INSTANCE;
      end
      if (ip_check && (frm_hdr.src_ip < ip_lo || frm_hdr.src_ip > ip_hi)) begin
        next_rej = aod_pkg::REJ_IP;
      end
      next_accept = (next_rej == aod_pkg::REJ_NONE);
    end else if (state == ST_RECV && frm_valid) begin
      next_pos     = pos + 6'h01;
      next_overrun = overrun | (pos == 6'h3f);
      if (accept && pos < pref_len) begin
        case (pos)
          aod_pkg::BYTE_CTRL:   next_st_ctrl = frm_data;
          aod_pkg::BYTE_SPD_LO: next_st_spd[7:0] = frm_data;
          aod_pkg::BYTE_SPD_HI: next_st_spd[15:8] = frm_data;
          aod_pkg::BYTE_TRQ_LO: next_st_trq[7:0] = frm_data;
          aod_pkg::BYTE_TRQ_HI: next_st_trq[15:8] = frm_data;
          default: next_st_ctrl = st_ctrl;
        endcase
      end else if (accept && hit != 10'h000) begin
        for (int i = aod_pkg::NUM_ITEMS - 1; i >= 0; i--) begin
          if (hit[i]) begin
            k = 4'(i);
          end
        end
        b = pos - off[k];
        if (b == 6'h00) begin
          next_acc = {24'h000000, frm_data};
        end else begin
          next_acc[8*b[1:0] +: 8] = frm_data;
        end
        if (b[2:0] == len[k] - 3'h1 && item_exists[k]) begin
          next_item_wr_valid    = 1'b1;
          next_item_wr.item     = k;
          next_item_wr.selector = sel[k];
          next_item_wr.subindex = k[0] ? subidx[k[3:1]][15:8]
                                       : subidx[k[3:1]][7:0];
          next_item_wr.value    = next_acc;
        end
      end
      if (frm_last) begin
        next_state    = ST_IDLE;
        next_frm_done = 1'b1;
        if (accept && (next_overrun || next_pos != exp_len)) begin
          next_rej = aod_pkg::REJ_LENGTH;
        end
        next_frm_ok   = (next_rej == aod_pkg::REJ_NONE);
        next_last_rej = next_rej;
        if (next_frm_ok) begin
          next_ok_count = ok_count + 16'h0001;
        end
        if (next_frm_ok && pref_len != 6'h00) begin
          next_cmd_update              = 1'b1;
          next_cmd.run_fwd             = next_st_ctrl[aod_pkg::BIT_RUN_FWD];
          next_cmd.fault_reset         = next_st_ctrl[aod_pkg::BIT_FAULT_RST];
          next_cmd.speed_ref           = next_st_spd;
          next_cmd.run_rev             = is_ext(fmt) &
                                         next_st_ctrl[aod_pkg::BIT_RUN_REV];
          next_cmd.net_control_select  = is_ext(fmt) &
                                         next_st_ctrl[aod_pkg::BIT_NET_CTRL];
          next_cmd.net_reference_select = is_ext(fmt) &
                                         next_st_ctrl[aod_pkg::BIT_NET_REF];
          if (has_trq(fmt)) begin
            next_cmd.torque_ref = next_st_trq;
          end
        end
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state         <= ST_IDLE;
      pos           <= 6'h00;
      accept        <= 1'b0;
      rej           <= aod_pkg::REJ_NONE;
      fmt           <= 8'h00;
      exp_len       <= 6'h00;
      pref_len      <= 6'h00;
      overrun       <= 1'b0;
      st_ctrl       <= 8'h00;
      st_spd        <= 16'h0000;
      st_trq        <= 16'h0000;
      acc           <= 32'h0000_0000;
      cmd           <= '0;
      item_wr       <= '0;
      item_wr_valid <= 1'b0;
      cmd_update    <= 1'b0;
      frm_done      <= 1'b0;
      frm_ok        <= 1'b0;
      ok_count      <= 16'h0000;
      last_rej      <= aod_pkg::REJ_NONE;
    end else begin
      state         <= next_state;
      pos           <= next_pos;
      accept        <= next_accept;
      rej           <= next_rej;
      fmt           <= next_fmt;
      exp_len       <= next_exp_len;
      pref_len      <= next_pref_len;
      overrun       <= next_overrun;
      st_ctrl       <= next_st_ctrl;
      st_spd        <= next_st_spd;
      st_trq        <= next_st_trq;
      acc           <= next_acc;
      cmd           <= next_cmd;
      item_wr       <= next_item_wr;
      item_wr_valid <= next_item_wr_valid;
      cmd_update    <= next_cmd_update;
      frm_done      <= next_frm_done;
      frm_ok        <= next_frm_ok;
      ok_count      <= next_ok_count;
      last_rej      <= next_last_rej;
    end
  end

  // Last value of each user item, readable as instance data
  aod_item_mem u_item_mem (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr_en   (next_item_wr_valid),
    .wr_addr (next_item_wr.item),
    .wr_data (next_item_wr.value),
    .rd_addr (mem_raddr),
    .rd_data (mem_rdata)
  );
endmodule // aod_decoder

// ### aod_pkg.sv
// Constants and carrier types for the assembly output decoder
package aod_pkg;

  // Consuming assembly instance numbers
  localparam logic [7:0]  INST_BASIC     = 8'h14;
  localparam logic [7:0]  INST_EXT       = 8'h15;
  localparam logic [7:0]  INST_SPD_TRQ   = 8'h16;
  localparam logic [7:0]  INST_EXT_TRQ   = 8'h17;
  localparam logic [7:0]  INST_CONFIG    = 8'h64;

  // Class attributes
  localparam logic [15:0] CLASS_REVISION = 16'h0002;
  localparam logic [15:0] MAX_INSTANCE   = 16'h0064;

  // Selector value that means "no data"
  localparam logic [15:0] SEL_NONE       = 16'h270f;
  localparam int          NUM_ITEMS      = 10;
  localparam int          NUM_SUBIDX     = 5;

  // Frame lengths in bytes
  localparam logic [5:0]  LEN_SPEED      = 6'h04;
  localparam logic [5:0]  LEN_SPEED_TRQ  = 6'h06;

  // Byte positions inside the fixed layouts
  localparam logic [5:0]  BYTE_CTRL      = 6'h00;
  localparam logic [5:0]  BYTE_SPD_LO    = 6'h02;
  localparam logic [5:0]  BYTE_SPD_HI    = 6'h03;
  localparam logic [5:0]  BYTE_TRQ_LO    = 6'h04;
  localparam logic [5:0]  BYTE_TRQ_HI    = 6'h05;

  // Bit positions in the control byte
  localparam int          BIT_RUN_FWD    = 0;
  localparam int          BIT_RUN_REV    = 1;
  localparam int          BIT_FAULT_RST  = 2;
  localparam int          BIT_NET_CTRL   = 5;
  localparam int          BIT_NET_REF    = 6;

  // Register byte addresses
  localparam logic [7:0]  ADDR_CLASS_REV = 8'h00;
  localparam logic [7:0]  ADDR_MAX_INST  = 8'h04;
  localparam logic [7:0]  ADDR_FORMAT    = 8'h08;
  localparam logic [7:0]  ADDR_IP_CTRL   = 8'h0c;
  localparam logic [7:0]  ADDR_IP_LO     = 8'h10;
  localparam logic [7:0]  ADDR_IP_HI     = 8'h14;
  localparam logic [7:0]  ADDR_STATUS    = 8'h18;
  localparam logic [7:0]  ADDR_SEL_BASE  = 8'h20;
  localparam logic [7:0]  ADDR_SUB_BASE  = 8'h48;
  localparam logic [7:0]  ADDR_VAL_BASE  = 8'h60;

  // Values after reset
  localparam logic [15:0] RST_FORMAT     = 16'h270f;
  localparam logic [15:0] RST_SELECTOR   = 16'h270f;
  localparam logic [15:0] RST_SUBIDX     = 16'h0000;
  localparam logic [31:0] RST_IP         = 32'h0000_0000;

  // Reject reasons shown in the status register
  localparam logic [2:0]  REJ_NONE       = 3'h0;
  localparam logic [2:0]  REJ_IP         = 3'h1;
  localparam logic [2:0]  REJ_INSTANCE   = 3'h2;
  localparam logic [2:0]  REJ_LENGTH     = 3'h3;
  localparam logic [2:0]  REJ_NO_CONN    = 3'h4;

  typedef struct packed {
    logic [7:0]  inst_no;
    logic [31:0] src_ip;
  } aod_frame_hdr_t;

  typedef struct packed {
    logic        run_fwd;
    logic        run_rev;
    logic        fault_reset;
    logic        net_control_select;
    logic        net_reference_select;
    logic [15:0] speed_ref;
    logic [15:0] torque_ref;
  } aod_drive_cmd_t;

  typedef struct packed {
    logic [3:0]  item;
    logic [15:0] selector;
    logic [7:0]  subindex;
    logic [31:0] value;
  } aod_item_wr_t;

endpackage

// ### aod_item_mem.sv
// Ten-word store of the last received user item values
`timescale 1ns/1ps
module aod_item_mem (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Write port
  input  wire logic        wr_en,
  input  wire logic [3:0]  wr_addr,
  input  wire logic [31:0] wr_data,
  // Read port
  input  wire logic [3:0]  rd_addr,
  output logic      [31:0] rd_data
);
  logic [31:0] mem [aod_pkg::NUM_ITEMS];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data <= 32'h0000_0000;
    end else if (rd_addr < 4'(aod_pkg::NUM_ITEMS)) begin
      rd_data <= mem[rd_addr];
    end else begin
      rd_data <= 32'h0000_0000;
    end
  end
endmodule // aod_item_mem

// ### aod_decoder_props.sv
// Checker of the decoder's bus and frame timing
`timescale 1ns/1ps
module aod_decoder_props (
  // Clock and reset
  input wire logic                    clk,
  input wire logic                    sys_rst,
  // Watched ports
  input wire logic                    avs_read,
  input wire logic                    avs_write,
  input wire logic                    avs_waitrequest,
  input wire logic                    frm_valid,
  input wire logic                    frm_last,
  input wire logic                    frm_done,
  input wire logic                    frm_ok,
  input wire logic                    cmd_update,
  input wire aod_pkg::aod_drive_cmd_t cmd,
  input wire logic                    item_wr_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_wait_one_cycle: assert property (
    (avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  a_idle_no_wait: assert property (
    !(avs_read | avs_write) |-> !avs_waitrequest)
    else $error("wait without request");
  a_done_after_last: assert property (
    frm_valid && frm_last |=> frm_done) else $error("no frame end");
  a_done_single: assert property (
    frm_done |=> !frm_done) else $error("frame end too long");
  a_update_on_ok: assert property (
    cmd_update |-> frm_done && frm_ok) else $error("bad update");
  a_cmd_held: assert property (
    !$stable(cmd) |-> cmd_update) else $error("command changed");
  a_ok_held: assert property (
    !$stable(frm_ok) |-> frm_done) else $error("result changed");
  a_item_after_byte: assert property (
    item_wr_valid |-> $past(frm_valid)) else $error("item write late");
endmodule // aod_decoder_props
bind aod_decoder aod_decoder_props i_props (.*);

// ### aod_scan_model.sv
// Scanner model that sends consuming assembly frames
`timescale 1ns/1ps
module aod_scan_model (
  // Clock
  input  wire logic               clk,
  // Frame link
  output logic                    frm_start,
  output aod_pkg::aod_frame_hdr_t frm_hdr,
  output logic                    frm_valid,
  output logic [7:0]              frm_data,
  output logic                    frm_last
);
  initial begin
    frm_start = 1'b0;
    frm_hdr = '0;
    frm_valid = 1'b0;
    frm_data = 8'h00;
    frm_last = 1'b0;
  end
  // Header, then bytes in frame order, low byte first
  task automatic send(input logic [7:0] inst, input logic [31:0] ip,
                      input logic [7:0] b [$]);
    @(posedge clk);
    frm_start <= 1'b1;
    frm_hdr <= '{inst, ip};
    foreach (b[i]) begin
      @(posedge clk);
      frm_start <= 1'b0;
      frm_valid <= 1'b1;
      frm_data <= b[i];
      frm_last <= (i == b.size() - 1);
    end
    @(posedge clk);
    frm_valid <= 1'b0;
    frm_last <= 1'b0;
    frm_data <= ~frm_data;
    frm_hdr <= ~frm_hdr;
  endtask
endmodule // aod_scan_model

// ### tb_aod_decoder.sv
// Self-checking bench of the assembly output decoder
`timescale 1ns/1ps
module tb_aod_decoder;
  typedef struct {
    logic [7:0]              inst;
    int                      len;
    logic [7:0]              b [6];
    aod_pkg::aod_drive_cmd_t exp;
    logic                    ok;
  } aod_row_t;
  logic                    clk = 1'b0;
  logic                    sys_rst = 1'b1;
  logic [7:0]              avs_address = 8'h00;
  logic                    avs_read = 1'b0;
  logic                    avs_write = 1'b0;
  logic [31:0]             avs_writedata = 32'h0;
  logic [3:0]              avs_byteenable = 4'hf;
  logic [31:0]             avs_readdata;
  logic                    avs_waitrequest;
  logic                    frm_start, frm_valid, frm_last;
  logic                    frm_done, frm_ok;
  aod_pkg::aod_frame_hdr_t frm_hdr;
  logic [7:0]              frm_data;
  logic [9:0]              item_exists = 10'h3fb;
  logic [9:0][1:0]         item_size_m1 = {10{2'h1}};
  aod_pkg::aod_drive_cmd_t cmd;
  logic                    cmd_update, item_wr_valid, conn_enabled;
  aod_pkg::aod_item_wr_t   item_wr, last_wr;
  int                      n_errors = 0;
  int                      comparisons = 0;
  int                      n_wr = 0;
  logic [31:0]             q;
  logic [7:0]              fb [$];
  aod_row_t                rows [6];
  aod_decoder    i_dut (.*);
  aod_scan_model i_scan (.*);
  always #20 clk = ~clk;
  always @(posedge clk) begin
    if (item_wr_valid === 1'b1) begin
      n_wr <= n_wr + 1;
      last_wr <= item_wr;
    end
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 20);
    if (i >= 20) begin
      n_errors++;
      summarize();
    end else begin
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask
  task automatic frame(input logic [7:0] inst, input logic [31:0] ip);
    i_scan.send(inst, ip, fb);
    @(negedge clk);
    check(frm_done, 1'b1);
  endtask
  initial begin
    rows[0] = '{8'h14, 4, '{8'hff, 8'hab, 8'h34, 8'h12, 8'h0, 8'h0},
                '{1, 0, 1, 0, 0, 16'h1234, 16'h0}, 1};
    rows[1] = '{8'h15, 4, '{8'h63, 8'h00, 8'hcd, 8'hab, 8'h0, 8'h0},
                '{1, 1, 0, 1, 1, 16'habcd, 16'h0}, 1};
    rows[2] = '{8'h16, 6, '{8'h06, 8'h00, 8'h01, 8'h02, 8'h03, 8'h04},
                '{0, 0, 1, 0, 0, 16'h0201, 16'h0403}, 1};
    rows[3] = '{8'h17, 6, '{8'h22, 8'h00, 8'h11, 8'h22, 8'h33, 8'h44},
                '{0, 1, 0, 1, 0, 16'h2211, 16'h4433}, 1};
    rows[4] = '{8'h15, 6, rows[3].b, rows[3].exp, 0};
    rows[5] = '{8'h18, 4, rows[3].b, rows[3].exp, 0};
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (rows[r]) begin
      fb = {};
      for (int i = 0; i < rows[r].len; i++)
        fb.push_back(rows[r].b[i]);
      frame(rows[r].inst, 32'h0);
      check(frm_ok, rows[r].ok);
      check(cmd, rows[r].exp);
      $display("row %0d done", r);
    end
    bus(1, 8'h00, 32'hffff);
    check(q, 32'h0);
    bus(0, 8'h00, 0);
    check(q, 32'h2);
    bus(0, 8'h04, 0);
    check(q, 32'h64);
    bus(0, 8'h08, 0);
    check(q, 32'h270f);
    check(conn_enabled, 1'b0);
    fb = {8'h01, 8'h00, 8'h78, 8'h56};
    frame(8'h64, 32'h0);
    check(frm_ok, 1'b0);
    bus(0, 8'h18, 0);
    check(q[3:1], 3'h4);
    $display("registers and no connection done");
    bus(1, 8'h08, 32'h14);
    bus(1, 8'h20, 32'h0101);
    bus(1, 8'h24, 32'h0101);
    bus(1, 8'h28, 32'h0202);
    bus(1, 8'h48, 32'hbbaa);
    item_size_m1[2] <= 2'h0;
    check(conn_enabled, 1'b1);
    fb = {8'h01, 8'h00, 8'h78, 8'h56, 8'h11, 8'h22, 8'h33};
    n_wr = 0;
    frame(8'h64, 32'h0);
    check(frm_ok, 1'b1);
    check(cmd, {5'h10, 16'h5678, 16'h4433});
    check(n_wr, 1);
    check(last_wr.value, 32'h2211);
    check(last_wr.subindex, 8'haa);
    check(last_wr.selector, 16'h0101);
    check(last_wr.item, 4'h0);
    bus(0, 8'h60, 0);
    check(q, 32'h2211);
    bus(1, 8'h08, 32'h16);
    fb = {8'h04, 8'h00, 8'h02, 8'h01, 8'h04, 8'h03, 8'h55, 8'h66, 8'h77};
    frame(8'h64, 32'h0);
    check(frm_ok, 1'b1);
    check(cmd, {5'h04, 16'h0102, 16'h0304});
    check(last_wr.value, 32'h6655);
    $display("configurable frame done");
    bus(1, 8'h0c, 32'h1);
    bus(1, 8'h10, 32'h0a000001);
    bus(1, 8'h14, 32'h0a000005);
    fb = {8'h01, 8'h00, 8'h9a, 8'h78};
    frame(8'h14, 32'h0a000009);
    check(frm_ok, 1'b0);
    check(cmd.speed_ref, 16'h0102);
    bus(0, 8'h18, 0);
    check(q[3:1], 3'h1);
    frame(8'h14, 32'h0a000005);
    check(cmd.speed_ref, 16'h789a);
    $display("address filter done");
    @(posedge clk);
    sys_rst <= 1'b1;
    @(negedge clk);
    check({cmd, frm_ok, conn_enabled}, 0);
    $display("reset done");
    summarize();
  end
endmodule // tb_aod_decoder
